//--- design/aux_converter_control.sv
// auxiliary converter control: serial registers, adc sequencing, dac settings
// Summary of operation
// - each write to aux_adc_start_channel starts a conversion
// - write done on eighth data edge, start next tick
// - conversion lasts 20 to 34 conversion clocks
// - length N comes from aux_adc_timing delay field
// - result reported as straight unsigned binary
// - 10-bit code drives span current inverted
// - first code dac10_first_code_high/dac10_first_code_low, second dac10_second_code_high/dac10_second_code_low
// - each 10-bit dac: enable, top, span selects
// - each 12-bit dac configured independently, own output
// - reference bit and range bit pick full scale
// - conversion clock is core clock binary divided
// - three-bit channel field in aux_adc_start_channel picks input
// - two-bit delay field lengthens the conversion
module aux_converter_control (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic aux_conversion_clock,
  output logic [2:0] adc_channel_select,
  output logic adc_converting,
  input wire logic [11:0] adc_sample_data,
  output logic [9:0] dac10_first_span_code,
  output logic [9:0] dac10_second_span_code,
  output logic [1:0] dac10_enable,
  output logic [5:0] dac10_top_select,
  output logic [3:0] dac_range_select,
  output logic [11:0] dac12_first_output,
  output logic [11:0] dac12_second_output,
  output logic [1:0] dac12_enable,
  output logic [1:0] dac12_reference_select,
  output logic [1:0] dac12_range_select
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT_TICK = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_t;

  logic [2:0] sclk_sync_reg;
  logic [1:0] csb_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic csb_s;
  logic [3:0] bit_cnt_reg;
  logic [7:0] instr_reg;
  logic [6:0] data_shift_reg;
  logic [7:0] out_shift_reg;
  logic [7:0] read_data;
  logic write_done;
  logic [7:0] dac10_second_high_reg;
  logic [7:0] dac10_second_low_reg;
  logic [7:0] dac10_first_high_reg;
  logic [7:0] dac10_first_low_reg;
  logic [7:0] dac12_config_reg;
  logic [7:0] dac12_first_high_reg;
  logic [7:0] dac12_first_low_reg;
  logic [7:0] dac12_second_high_reg;
  logic [7:0] dac12_second_low_reg;
  logic [7:0] start_channel_reg;
  logic [7:0] divide_reg;
  logic [7:0] timing_reg;
  logic [11:0] result_reg;
  logic [7:0] div_cnt_reg;
  logic [7:0] div_limit;
  logic aux_tick;
  logic aux_clk_reg;
  conv_state_t state_reg;
  logic [5:0] conv_cnt_reg;
  logic [5:0] conv_len;

  // pin synchronisers; stage one feeds only stage two
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclk_sync_reg <= 3'h0;
      csb_sync_reg <= 2'h3;
      sdi_sync_reg <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      csb_sync_reg <= {csb_sync_reg[0], csb_n};
      sdi_sync_reg <= {sdi_sync_reg[0], sdi};
    end
  end
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign csb_s = csb_sync_reg[1];

  // serial frame shift and bit count
  always_ff @(posedge core_clk) begin
    if (!rst_n || csb_s) begin
      bit_cnt_reg <= 4'h0;
      instr_reg <= 8'h00;
      data_shift_reg <= 7'h00;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (bit_cnt_reg <= aux_conv_pkg::LAST_INSTR_BIT) begin
        instr_reg <= {instr_reg[6:0], sdi_sync_reg[1]};
      end else begin
        data_shift_reg <= {data_shift_reg[5:0], sdi_sync_reg[1]};
      end
    end
  end

  // write commits on the eighth rising edge of the data byte
  assign write_done = !csb_s && sclk_rise && !instr_reg[7]
    && bit_cnt_reg == aux_conv_pkg::LAST_DATA_BIT;

  // register writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dac10_second_high_reg <= aux_conv_pkg::REG_RESET;
      dac10_second_low_reg <= aux_conv_pkg::REG_RESET;
      dac10_first_high_reg <= aux_conv_pkg::REG_RESET;
      dac10_first_low_reg <= aux_conv_pkg::REG_RESET;
      dac12_config_reg <= aux_conv_pkg::REG_RESET;
      dac12_first_high_reg <= aux_conv_pkg::REG_RESET;
      dac12_first_low_reg <= aux_conv_pkg::REG_RESET;
      dac12_second_high_reg <= aux_conv_pkg::REG_RESET;
      dac12_second_low_reg <= aux_conv_pkg::REG_RESET;
      start_channel_reg <= aux_conv_pkg::REG_RESET;
      divide_reg <= aux_conv_pkg::REG_RESET;
      timing_reg <= aux_conv_pkg::REG_RESET;
    end else if (write_done) begin
      case (instr_reg[6:0])
        aux_conv_pkg::DAC10_SECOND_CODE_HIGH_ADDR: dac10_second_high_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::DAC10_SECOND_CODE_LOW_ADDR: dac10_second_low_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::DAC10_FIRST_CODE_HIGH_ADDR: dac10_first_high_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::DAC10_FIRST_CODE_LOW_ADDR: dac10_first_low_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::DAC12_CONFIG_ADDR: dac12_config_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::DAC12_FIRST_HIGH_ADDR: dac12_first_high_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::DAC12_FIRST_LOW_ADDR: dac12_first_low_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::DAC12_SECOND_HIGH_ADDR: dac12_second_high_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::DAC12_SECOND_LOW_ADDR: dac12_second_low_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::AUX_ADC_START_CHANNEL_ADDR: start_channel_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::AUX_CLOCK_DIVIDE_ADDR: divide_reg <= {data_shift_reg, sdi_sync_reg[1]};
        aux_conv_pkg::AUX_ADC_TIMING_ADDR: timing_reg <= {data_shift_reg, sdi_sync_reg[1]};
        default: ;
      endcase
    end
  end

  // read mux
  always_comb begin
    case (instr_reg[6:0])
      aux_conv_pkg::DAC10_SECOND_CODE_HIGH_ADDR: read_data = dac10_second_high_reg;
      aux_conv_pkg::DAC10_SECOND_CODE_LOW_ADDR: read_data = dac10_second_low_reg;
      aux_conv_pkg::DAC10_FIRST_CODE_HIGH_ADDR: read_data = dac10_first_high_reg;
      aux_conv_pkg::DAC10_FIRST_CODE_LOW_ADDR: read_data = dac10_first_low_reg;
      aux_conv_pkg::DAC12_CONFIG_ADDR: read_data = dac12_config_reg;
      aux_conv_pkg::DAC12_FIRST_HIGH_ADDR: read_data = dac12_first_high_reg;
      aux_conv_pkg::DAC12_FIRST_LOW_ADDR: read_data = dac12_first_low_reg;
      aux_conv_pkg::DAC12_SECOND_HIGH_ADDR: read_data = dac12_second_high_reg;
      aux_conv_pkg::DAC12_SECOND_LOW_ADDR: read_data = dac12_second_low_reg;
      aux_conv_pkg::AUX_ADC_START_CHANNEL_ADDR: read_data = start_channel_reg;
      aux_conv_pkg::AUX_ADC_RESULT_HIGH_ADDR: read_data = result_reg[11:4];
      aux_conv_pkg::AUX_ADC_RESULT_LOW_ADDR: read_data = {result_reg[3:0], 4'h0};
      aux_conv_pkg::AUX_CLOCK_DIVIDE_ADDR: read_data = divide_reg;
      aux_conv_pkg::AUX_ADC_TIMING_ADDR: read_data = timing_reg;
      default: read_data = 8'h00;
    endcase
  end

  // read data loads after the instruction byte, shifts out on falling edges
  always_ff @(posedge core_clk) begin
    if (!rst_n || csb_s) begin
      out_shift_reg <= 8'h00;
      sdo_oe <= 1'b0;
    end else if (sclk_fall && bit_cnt_reg == 4'h8 && instr_reg[7]) begin
      out_shift_reg <= read_data;
      sdo_oe <= 1'b1;
    end else if (sclk_fall && sdo_oe) begin
      out_shift_reg <= {out_shift_reg[6:0], 1'b0};
    end
  end
  assign sdo = out_shift_reg[7];

  // binary divider makes the conversion clock
  assign div_limit = 8'((9'h1 << divide_reg[aux_conv_pkg::DIVIDE_LSB +: 3]) - 9'h1);
  // tick where the conversion clock rises
  assign aux_tick = !aux_clk_reg && div_cnt_reg >= div_limit;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= 8'h00;
      aux_clk_reg <= 1'b0;
    end else if (div_cnt_reg >= div_limit) begin
      div_cnt_reg <= 8'h00;
      aux_clk_reg <= ~aux_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end
  assign aux_conversion_clock = aux_clk_reg;

  // delay field picks the conversion length
  always_comb begin
    case (timing_reg[aux_conv_pkg::DELAY_LSB +: 2])
      2'h0: conv_len = aux_conv_pkg::CONV_LEN_0;
      2'h1: conv_len = aux_conv_pkg::CONV_LEN_1;
      2'h2: conv_len = aux_conv_pkg::CONV_LEN_2;
      default: conv_len = aux_conv_pkg::CONV_LEN_3;
    endcase
  end

  // conversion sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      conv_cnt_reg <= 6'h00;
      result_reg <= 12'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (write_done && instr_reg[6:0] == aux_conv_pkg::AUX_ADC_START_CHANNEL_ADDR) begin
            state_reg <= ST_WAIT_TICK;
          end
        end
        ST_WAIT_TICK: begin
          if (aux_tick) begin
            state_reg <= ST_CONVERT;
            conv_cnt_reg <= 6'h01;
          end
        end
        ST_CONVERT: begin
          if (write_done && instr_reg[6:0] == aux_conv_pkg::AUX_ADC_START_CHANNEL_ADDR) begin
            state_reg <= ST_WAIT_TICK;
          end else if (aux_tick) begin
            if (conv_cnt_reg >= conv_len) begin
              state_reg <= ST_IDLE;
              result_reg <= adc_sample_data;
            end else begin
              conv_cnt_reg <= conv_cnt_reg + 6'h01;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign adc_converting = state_reg == ST_CONVERT;
  assign adc_channel_select = start_channel_reg[aux_conv_pkg::CHANNEL_LSB +: 3];

  // dac settings
  assign dac10_first_span_code = ~{dac10_first_high_reg, dac10_first_low_reg[7:6]};
  assign dac10_second_span_code = ~{dac10_second_high_reg, dac10_second_low_reg[7:6]};
  assign dac10_enable = {dac10_second_low_reg[aux_conv_pkg::DAC10_ENABLE_BIT],
    dac10_first_low_reg[aux_conv_pkg::DAC10_ENABLE_BIT]};
  assign dac10_top_select = {dac10_second_low_reg[aux_conv_pkg::DAC10_TOP_LSB +: 3],
    dac10_first_low_reg[aux_conv_pkg::DAC10_TOP_LSB +: 3]};
  assign dac_range_select = {dac10_second_low_reg[aux_conv_pkg::DAC10_SPAN_LSB +: 2],
    dac10_first_low_reg[aux_conv_pkg::DAC10_SPAN_LSB +: 2]};
  assign dac12_first_output = {dac12_first_high_reg, dac12_first_low_reg[7:4]};
  assign dac12_second_output = {dac12_second_high_reg, dac12_second_low_reg[7:4]};
  genvar g;
  for (g = 0; g < 2; g++) begin : g_dac12
    assign dac12_enable[g] = dac12_config_reg[g * aux_conv_pkg::DAC12_FIELD_STRIDE];
    assign dac12_reference_select[g] = dac12_config_reg[g * aux_conv_pkg::DAC12_FIELD_STRIDE + 1];
    assign dac12_range_select[g] = dac12_config_reg[g * aux_conv_pkg::DAC12_FIELD_STRIDE + 2];
  end
endmodule // aux_converter_control

//--- design/aux_conv_pkg.sv
// constants for the auxiliary converter control block
package aux_conv_pkg;
  // serial register map
  localparam logic [6:0] DAC12_CONFIG_ADDR = 7'h42;
  localparam logic [6:0] DAC10_SECOND_CODE_HIGH_ADDR = 7'h46;
  localparam logic [6:0] DAC10_SECOND_CODE_LOW_ADDR = 7'h47;
  localparam logic [6:0] DAC10_FIRST_CODE_HIGH_ADDR = 7'h49;
  localparam logic [6:0] DAC10_FIRST_CODE_LOW_ADDR = 7'h4a;
  localparam logic [6:0] DAC12_FIRST_HIGH_ADDR = 7'h4b;
  localparam logic [6:0] DAC12_FIRST_LOW_ADDR = 7'h4c;
  localparam logic [6:0] DAC12_SECOND_HIGH_ADDR = 7'h4d;
  localparam logic [6:0] DAC12_SECOND_LOW_ADDR = 7'h4e;
  localparam logic [6:0] AUX_ADC_START_CHANNEL_ADDR = 7'h77;
  localparam logic [6:0] AUX_ADC_RESULT_HIGH_ADDR = 7'h78;
  localparam logic [6:0] AUX_ADC_RESULT_LOW_ADDR = 7'h79;
  localparam logic [6:0] AUX_CLOCK_DIVIDE_ADDR = 7'h7a;
  localparam logic [6:0] AUX_ADC_TIMING_ADDR = 7'h7b;
  // field positions
  localparam int CHANNEL_LSB = 0;
  localparam int DELAY_LSB = 0;
  localparam int DIVIDE_LSB = 0;
  localparam int DAC10_ENABLE_BIT = 5;
  localparam int DAC10_TOP_LSB = 2;
  localparam int DAC10_SPAN_LSB = 0;
  localparam int DAC12_FIELD_STRIDE = 3;
  // reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;
  // serial frame: read flag then 7-bit address then 8 data bits
  localparam logic [3:0] LAST_INSTR_BIT = 4'h7;
  localparam logic [3:0] LAST_DATA_BIT = 4'hf;
  // conversion lengths in conversion clock cycles per delay setting
  localparam logic [5:0] CONV_LEN_0 = 6'h14;
  localparam logic [5:0] CONV_LEN_1 = 6'h18;
  localparam logic [5:0] CONV_LEN_2 = 6'h1c;
  localparam logic [5:0] CONV_LEN_3 = 6'h22;
endpackage

//--- tb/aux_conv_sva.sv
// port assertions for the auxiliary converter control
module aux_conv_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic aux_conversion_clock,
  input wire logic [2:0] adc_channel_select,
  input wire logic adc_converting,
  input wire logic [9:0] dac10_first_span_code,
  input wire logic [11:0] dac12_first_output
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] cs_age;
  logic [5:0] ticks;
  always_ff @(posedge core_clk) begin
    if (!rst_n || !csb_n) cs_age <= 9'h000;
    else if (cs_age != 9'h1ff) cs_age <= cs_age + 9'h001;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n || $rose(adc_converting)) ticks <= 6'h00;
    else if ($rose(aux_conversion_clock) && ticks != 6'h3f) ticks <= ticks + 6'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_frame_near;
    cs_age < 9'h008;
  endsequence
  property p_dac_cfg;
    $changed(dac12_first_output) || $changed(dac10_first_span_code) |-> s_frame_near;
  endproperty
  a_dac_cfg: assert property (p_dac_cfg) else $error("dac setting moved outside a frame");
  property p_chan;
    $changed(adc_channel_select) |-> s_frame_near;
  endproperty
  a_chan: assert property (p_chan) else $error("channel moved outside a frame");
  property p_oe;
    sdo_oe |-> s_frame_near;
  endproperty
  a_oe: assert property (p_oe) else $error("sdo driven outside a frame");
  property p_sdo;
    $changed(sdo) |-> !sclk;
  endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved while sclk high");
  property p_aux;
    $rose(aux_conversion_clock) |=> !$rose(aux_conversion_clock);
  endproperty
  a_aux: assert property (p_aux) else $error("conversion clock too fast");
  property p_start;
    $rose(adc_converting) |-> $rose(aux_conversion_clock);
  endproperty
  a_start: assert property (p_start) else $error("start off a conversion tick");
  property p_cause;
    $rose(adc_converting) |-> cs_age < 9'h120;
  endproperty
  a_cause: assert property (p_cause) else $error("conversion without a write");
  property p_len;
    $fell(adc_converting) |-> ticks >= 6'h13;
  endproperty
  a_len: assert property (p_len) else $error("conversion too short");
endmodule // aux_conv_sva
bind aux_converter_control aux_conv_sva i_sva (.core_clk, .rst_n, .sclk, .csb_n, .sdo, .sdo_oe,
  .aux_conversion_clock, .adc_channel_select, .adc_converting, .dac10_first_span_code,
  .dac12_first_output);

//--- tb/spi_host_model.sv
// serial host model issuing register frames
module spi_host_model (
  input wire logic core_clk,
  output logic sclk,
  output logic csb_n,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdi = 1'b0;
  end
  // read flag, address, data byte, msb first
  task automatic xfer(input logic [15:0] w, output logic [7:0] q);
    q = 8'h00;
    @(negedge core_clk) csb_n = 1'b0;
    repeat (3) @(negedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      repeat (5) @(negedge core_clk);
      if (i < 8) q = {q[6:0], sdo};
      sclk = 1'b1;
      repeat (4) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (6) @(negedge core_clk);
    csb_n = 1'b1;
    sdi = ~sdi;
    repeat (4) @(negedge core_clk);
  endtask
endmodule // spi_host_model

//--- tb/tb_top.sv
// self-checking bench for the auxiliary converter control
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, sclk, csb_n, sdi, sdo, sdo_oe, aux_conversion_clock, adc_converting;
  logic [2:0] adc_channel_select;
  logic [11:0] adc_sample_data, smp, dac12_first_output, dac12_second_output;
  logic [9:0] dac10_first_span_code, dac10_second_span_code;
  logic [1:0] dac10_enable, dac12_enable, dac12_reference_select, dac12_range_select;
  logic [5:0] dac10_top_select;
  logic [3:0] dac_range_select;
  logic [7:0] r;
  logic [31:0] lfsr = 32'hbae21ddd;
  int err_count = 0, check_count = 0, run_len = 0, last_len = 0, done_cnt = 0, n;
  int mreg[int];
  int map_q[$] = '{'h42, 'h46, 'h47, 'h49, 'h4a, 'h4b, 'h4c, 'h4d, 'h4e, 'h77, 'h7a, 'h7b};
  int lens[4] = '{20, 24, 28, 34};
  aux_converter_control i_dut (.core_clk, .rst_n, .sclk, .csb_n, .sdi, .sdo, .sdo_oe,
    .aux_conversion_clock, .adc_channel_select, .adc_converting, .adc_sample_data,
    .dac10_first_span_code, .dac10_second_span_code, .dac10_enable, .dac10_top_select,
    .dac_range_select, .dac12_first_output, .dac12_second_output, .dac12_enable,
    .dac12_reference_select, .dac12_range_select);
  spi_host_model i_host (.core_clk, .sclk, .csb_n, .sdi, .sdo);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (adc_converting) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
      done_cnt <= done_cnt + 1;
    end
  end
  function automatic logic [31:0] rnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input int a, input int d);
    i_host.xfer({1'b0, a[6:0], d[7:0]}, r);
    if (mreg.exists(a)) mreg[a] = d & 'hff;
  endtask
  task rdchk(input int a);
    i_host.xfer({1'b1, a[6:0], 8'h00}, r);
    chk({8'h00, r}, 16'(mreg.exists(a) ? mreg[a] : 0));
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    give_verdict;
  end
  initial begin
    rst_n = 1'b0;
    adc_sample_data = 12'h000;
    foreach (map_q[i]) mreg[map_q[i]] = 0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    foreach (map_q[i]) rdchk(map_q[i]);
    $display("reset value test done");
    repeat (2) begin
      foreach (map_q[i]) begin
        lfsr = rnd(lfsr);
        if (map_q[i] != 'h77) wr(map_q[i], lfsr[7:0]);
      end
      chk(16'(dac10_first_span_code), 16'(((mreg['h49] << 2) | (mreg['h4a] >> 6)) ^ 'h3ff));
      chk(16'(dac10_second_span_code), 16'(((mreg['h46] << 2) | (mreg['h47] >> 6)) ^ 'h3ff));
      chk({dac10_enable, dac10_top_select, dac_range_select}, {mreg['h47][5], mreg['h4a][5],
        mreg['h47][4:2], mreg['h4a][4:2], mreg['h47][1:0], mreg['h4a][1:0]});
      chk(16'(dac12_first_output), 16'((mreg['h4b] << 4) | (mreg['h4c] >> 4)));
      chk(16'(dac12_second_output), 16'((mreg['h4d] << 4) | (mreg['h4e] >> 4)));
      chk({dac12_enable, dac12_reference_select, dac12_range_select}, {mreg['h42][3],
        mreg['h42][0], mreg['h42][4], mreg['h42][1], mreg['h42][5], mreg['h42][2]});
      foreach (map_q[i]) rdchk(map_q[i]);
    end
    wr('h50, 'h5a);
    rdchk('h50);
    $display("register test done");
    wr('h7a, 0);
    repeat (1000) @(negedge core_clk);
    for (int d = 0; d < 4; d++) begin
      wr('h7b, d);
      lfsr = rnd(lfsr);
      smp = lfsr[11:0];
      adc_sample_data = smp;
      n = done_cnt;
      wr('h77, lfsr[15:8]);
      for (int k = 0; k < 600 && done_cnt == n; k++) @(negedge core_clk);
      if (done_cnt == n) begin
        err_count++;
        give_verdict;
      end
      chk(16'(last_len), 16'(2 * lens[d]));
      chk(16'(adc_channel_select), 16'(mreg['h77] & 7));
      adc_sample_data = ~smp;
      mreg['h78] = smp[11:4];
      mreg['h79] = {smp[3:0], 4'h0};
      rdchk('h78);
      rdchk('h79);
    end
    $display("conversion test done");
    give_verdict;
  end
endmodule // tb_top
